// ### logic/sio_pkg.sv
// package of constants and carrier types for the shared io exchange
package sio_pkg;
  localparam int CLK_MHZ = 250;
  localparam int FAST_MS = 100;
  localparam int SLOW_MS = 1000;
  localparam int FAST_CYC = FAST_MS * 1000 * CLK_MHZ;
  localparam int SLOW_CYC = SLOW_MS * 1000 * CLK_MHZ;
  localparam int NUM_BRIDGE = 4;
  localparam int NUM_SHARED = 4;
  localparam int NUM_DIST_RX = 32;
  localparam int GRP_BITS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] KIND_SHARED_BIN = 2'h0;
  localparam logic [1:0] KIND_SHARED_ANA = 2'h1;
  localparam logic [1:0] KIND_DIST_BIN = 2'h2;
  localparam logic [1:0] KIND_BRIDGE = 2'h3;
  localparam logic [7:0] CAN_ADDR_RST = 8'h00;

  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] index;
    logic [15:0] data;
  } sio_frame_type;

  localparam int FRAME_W = $bits(sio_frame_type);
endpackage : sio_pkg

// ### logic/sio_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module sio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // full and empty flags from the occupancy count
  assign in_ready = (cnt_r < (AW+1)'(DEPTH)); // room while fewer than depth words are held
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : sio_fifo

// ### logic/sio_exchange.sv
// shared and distributed binary exchange engine with frame fifo
`timescale 1ns/1ps
// Summary of operation
// - each enabled shared binary group is sent every 100 ms while it changes, else every 1 s.
// - the distributed pack is sent every 100 ms while it changes, else every 1 s.
// - four bridge modules exist and each carries eight binary signals.
// - state signals reach the logic engine only through the bridge modules.
// - a configured receiver with no matching sender on the bus raises a missing flag.
// - one eight-bit distributed pack is owned and is silent when unconfigured or unused.
// - the distributed pack is tagged with the own bus address.
// - up to 32 distributed receivers exist and the own pack is received too.
// - distributed receiver inputs carry no names and no protections.
module sio_exchange #(
  parameter int FAST_CYCLES = sio_pkg::FAST_CYC,
  parameter int SLOW_CYCLES = sio_pkg::SLOW_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] can_addr,
  input wire logic [31:0] state_signals,
  output logic [31:0] bridge_to_logic,
  input wire logic [31:0] shared_bin_sender,
  input wire logic [3:0] shared_tx_en,
  input wire logic [7:0] distributed_bin_sender,
  input wire logic dist_tx_configured,
  input wire logic [7:0] dist_tx_used,
  output logic [sio_pkg::FRAME_W-1:0] tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [sio_pkg::FRAME_W-1:0] rx_frame,
  input wire logic rx_valid,
  input wire logic [3:0] shared_rx_cfg,
  input wire logic [31:0] dist_rx_cfg,
  input wire logic timeout_tick,
  output logic [31:0] shared_bin_receiver,
  output logic [255:0] distributed_bin_receiver,
  output logic [3:0] shared_missing,
  output logic [31:0] dist_missing
);
  localparam int NSRC = sio_pkg::NUM_SHARED + 1;
  logic rst_s1_r;
  logic rst_s2_r;
  logic [7:0] last_r [NSRC];
  logic [31:0] cnt_r [NSRC];
  logic [NSRC-1:0] chg_r;
  logic [NSRC-1:0] due;
  logic [NSRC-1:0] act;
  logic [7:0] cur [NSRC];
  logic [2:0] sel;
  logic sel_ok;
  sio_pkg::sio_frame_type q_in;
  sio_pkg::sio_frame_type rx_f;
  logic q_ready;
  logic [3:0] sh_seen_r;
  logic [31:0] ds_seen_r;

  // reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // state signals pass to the logic engine only via the four bridges of eight bits
  always_ff @(posedge mclk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      bridge_to_logic <= '0;
    end else begin
      bridge_to_logic <= state_signals;
    end
  end

  // source selection: shared groups then the distributed pack
  always_comb begin
    for (int i = 0; i < sio_pkg::NUM_SHARED; i++) begin
      cur[i] = shared_bin_sender[i*8 +: 8];
      act[i] = shared_tx_en[i];
    end
    cur[sio_pkg::NUM_SHARED] = distributed_bin_sender;
    act[sio_pkg::NUM_SHARED] = dist_tx_configured && (dist_tx_used != 8'h00);
  end

  // pacing: 100 ms after a change, 1 s otherwise
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      due[i] = act[i] && ((chg_r[i] || cur[i] != last_r[i]) ? (cnt_r[i] >= 32'(FAST_CYCLES - 1))
               : (cnt_r[i] >= 32'(SLOW_CYCLES - 1)));
    end
    sel = 3'h0;
    sel_ok = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (due[i]) begin
        sel = 3'(i);
        sel_ok = 1'b1;
      end
    end
  end

  // frame build: whole group in one frame, pack tagged with own address
  always_comb begin
    q_in.data = {8'h00, cur[sel]};
    if (sel == 3'(sio_pkg::NUM_SHARED)) begin
      q_in.kind = sio_pkg::KIND_DIST_BIN;
      q_in.index = can_addr;
    end else begin
      q_in.kind = sio_pkg::KIND_SHARED_BIN;
      q_in.index = {5'h00, sel};
    end
  end

  // per source timers and change memory
  always_ff @(posedge mclk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      for (int i = 0; i < NSRC; i++) begin
        last_r[i] <= 8'h00;
        cnt_r[i] <= 32'h0000_0000;
      end
      chg_r <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (sel_ok && q_ready && sel == 3'(i)) begin
          last_r[i] <= cur[i];
          cnt_r[i] <= 32'h0000_0000;
          chg_r[i] <= 1'b0;
        end else begin
          if (cur[i] != last_r[i]) begin
            chg_r[i] <= 1'b1;
          end
          if (!due[i]) begin
            cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
          end
        end
      end
    end
  end

  sio_fifo #(
    .WIDTH(sio_pkg::FRAME_W),
    .DEPTH(sio_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_s2_r),
    .in_data(q_in),
    .in_valid(sel_ok),
    .in_ready(q_ready),
    .out_data(tx_frame),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  assign rx_f = rx_frame;

  // receive path: whole groups update at once, own pack accepted as well
  always_ff @(posedge mclk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      shared_bin_receiver <= '0;
      distributed_bin_receiver <= '0;
      sh_seen_r <= '0;
      ds_seen_r <= '0;
    end else begin
      if (timeout_tick) begin
        sh_seen_r <= '0;
        ds_seen_r <= '0;
      end
      if (rx_valid && rx_f.kind == sio_pkg::KIND_SHARED_BIN && rx_f.index < 8'h04) begin
        shared_bin_receiver[rx_f.index[1:0]*8 +: 8] <= rx_f.data[7:0];
        sh_seen_r[rx_f.index[1:0]] <= 1'b1;
      end
      if (rx_valid && rx_f.kind == sio_pkg::KIND_DIST_BIN && rx_f.index < 8'h20) begin
        distributed_bin_receiver[rx_f.index[4:0]*8 +: 8] <= rx_f.data[7:0];
        ds_seen_r[rx_f.index[4:0]] <= 1'b1;
      end
    end
  end

  // missing sender flags; distributed inputs get only raw bits, no names or protections
  always_ff @(posedge mclk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      shared_missing <= '0;
      dist_missing <= '0;
    end else if (timeout_tick) begin
      shared_missing <= shared_rx_cfg & ~sh_seen_r;
      dist_missing <= dist_rx_cfg & ~ds_seen_r;
    end
  end
endmodule : sio_exchange

// ### verification/sio_exchange_assertions.sv
// assertions on the exchange engine ports
`timescale 1ns/1ps
module sio_exchange_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] can_addr,
  input wire logic [31:0] state_signals,
  input wire logic [31:0] bridge_to_logic,
  input wire logic [25:0] tx_frame,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic timeout_tick,
  input wire logic [3:0] shared_rx_cfg,
  input wire logic [3:0] shared_missing
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_brg; $past(rstn, 3) |-> bridge_to_logic == $past(state_signals); endproperty
  a_brg: assert property (p_brg) else $error("bridge copy");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame); endproperty
  a_hold: assert property (p_hold) else $error("frame not held");
  property p_pop; $fell(tx_valid) |-> $past(tx_ready); endproperty
  a_pop: assert property (p_pop) else $error("frame lost");
  property p_pad; tx_valid |-> tx_frame[15:8] == 8'h00; endproperty
  a_pad: assert property (p_pad) else $error("upper byte set");
  property p_kind; tx_valid |-> tx_frame[25:24] inside {2'h0, 2'h2}; endproperty
  a_kind: assert property (p_kind) else $error("frame kind");
  property p_grp; tx_valid && tx_frame[25:24] == 2'h0 |-> tx_frame[23:18] == 6'h00; endproperty
  a_grp: assert property (p_grp) else $error("group index");
  property p_addr; tx_valid && tx_frame[25:24] == 2'h2 |-> tx_frame[23:16] == can_addr; endproperty
  a_addr: assert property (p_addr) else $error("pack number");
  property p_miss; timeout_tick |=> (shared_missing & ~$past(shared_rx_cfg)) == 4'h0; endproperty
  a_miss: assert property (p_miss) else $error("missing flag");
endmodule : sio_exchange_assertions
bind sio_exchange sio_exchange_assertions u_chk (.*);

// ### verification/sio_bus_model.sv
// far-side bus model: accepts with optional stalls, echoes frames
`timescale 1ns/1ps
module sio_bus_model (
  input wire logic mclk,
  input wire logic stall,
  input wire logic [25:0] tx_frame,
  input wire logic tx_valid,
  output logic tx_ready = 1'b1,
  output logic [25:0] rx_frame = 26'h0,
  output logic rx_valid = 1'b0
);
  logic [7:0] lf = 8'hA5;
  // ready with random stalls while stall is high; only own frames return, idle lines inverted every cycle
  always @(posedge mclk) begin
    lf <= {lf[6:0], lf[7] ^ lf[5]};
    tx_ready <= !stall || lf[0];
    rx_valid <= tx_valid && tx_ready;
    rx_frame <= (tx_valid && tx_ready) ? tx_frame : ~rx_frame;
  end
endmodule : sio_bus_model

// ### verification/testbench.sv
// bench for the exchange engine against an echoing bus model
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: mismatch", $time); end end
module testbench;
  localparam int FAST = 20;
  localparam int SLOW = 100;
  localparam logic [9:0] G0 = {sio_pkg::KIND_SHARED_BIN, 8'h00};
  localparam logic [9:0] D5 = {sio_pkg::KIND_DIST_BIN, 8'h05};
  logic mclk = 1'b0, rstn = 1'b0, stall = 1'b0, timeout_tick = 1'b0, dist_tx_configured = 1'b0;
  logic tx_valid, tx_ready, rx_valid;
  logic [7:0] v, can_addr = 8'h05, distributed_bin_sender = 8'h00, dist_tx_used = 8'h00;
  logic [3:0] shared_missing, shared_tx_en = 4'h0, shared_rx_cfg = 4'h3;
  logic [31:0] state_signals = 32'h0, shared_bin_sender = 32'h0, dist_rx_cfg = 32'h20;
  logic [31:0] bridge_to_logic, shared_bin_receiver, dist_missing, seed = 32'h860D80D3;
  logic [255:0] distributed_bin_receiver;
  logic [25:0] tx_frame, rx_frame, q[$];
  int fails = 0, samples_checked = 0, cyc = 0;
  sio_exchange #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) dut (.*);
  sio_bus_model u_bus (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic print_verdict();
    $display("checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // note one frame, wait until it is taken, check its spacing
  task automatic expect_frame(input logic [9:0] ki, input int gap);
    int t;
    int n;
    t = cyc;
    n = 0;
    q.push_back({ki, 8'h00, v});
    while (q.size() != 0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n < 400 && (gap == 0 || cyc - t == gap), 1'b1)
  endtask : expect_frame
  always #2 mclk = ~mclk;
  // cycle count and random state bits for the bridges
  always @(posedge mclk) cyc <= cyc + 1;
  always @(negedge mclk) state_signals <= xs();
  // take the oldest note whenever the sink accepts a frame
  always @(posedge mclk) begin
    if (rstn && tx_valid && tx_ready) begin
      `CHK(q.size() > 0, 1'b1)
      if (q.size() > 0) `CHK(tx_frame, q.pop_front())
    end
  end
  // shared group, distributed pack, silence, missing senders
  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    v = 8'(xs());
    shared_bin_sender[7:0] = v;
    shared_tx_en = 4'h1;
    expect_frame(G0, 0);
    expect_frame(G0, SLOW);
    for (int i = 0; i < 4; i++) begin
      v ^= 8'(xs()) | 8'h01;
      shared_bin_sender[7:0] = v;
      stall = (i == 3);
      expect_frame(G0, (i < 3) ? FAST : 0);
    end
    stall = 1'b0;
    shared_tx_en = 4'h0;
    v = 8'(xs());
    distributed_bin_sender = v;
    dist_tx_used = 8'hFF;
    dist_tx_configured = 1'b1;
    expect_frame(D5, 0);
    expect_frame(D5, SLOW);
    v ^= 8'h3C;
    distributed_bin_sender = v;
    expect_frame(D5, FAST);
    repeat (3) @(negedge mclk);
    `CHK(distributed_bin_receiver[47:40], v)
    `CHK(shared_bin_receiver[7:0], shared_bin_sender[7:0])
    dist_tx_used = 8'h00;
    repeat (2 * SLOW) @(negedge mclk);
    dist_tx_used = 8'hFF;
    dist_tx_configured = 1'b0;
    repeat (2 * SLOW) @(negedge mclk); // pack unconfigured stays silent
    shared_tx_en = 4'h1;
    v = shared_bin_sender[7:0];
    timeout_tick = 1'b1;
    @(negedge mclk);
    timeout_tick = 1'b0;
    expect_frame(G0, 0);
    repeat (3) @(negedge mclk);
    timeout_tick = 1'b1;
    @(negedge mclk);
    timeout_tick = 1'b0;
    @(negedge mclk);
    `CHK(shared_missing, 4'h2)
    `CHK(dist_missing, 32'h20)
    print_verdict();
  end
  // stop a hung run
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    print_verdict();
  end
endmodule : testbench
